// File: rx8_decoder.sv
// Receive-side 8b/10b decoder with per-byte flags and an APB control slave
//
// Operation
// R01 - Two, four or eight independent byte slices
// R02 - Running disparity chains slice to slice, word to word
// R03 - Reverse each symbol's bits before decoding
// R04 - Width selects valid bytes and byte order (code: width sets the valid byte count only, byte order is fixed)
// R05 - Bypass puts raw bit9, bit8, byte out
// R06 - Wrong running disparity raises disparity flag
// R07 - Unknown symbol raises not-in-table flag
// R08 - Unknown symbol passes raw ten bits out
// R09 - Control character raises K flag
// R10 - Plus-comma enable gates positive comma flag
// R11 - Minus-comma enable gates negative comma flag
// R12 - Standard-only flags just K28.1, .5, .7
// R13 - Decode enable high decodes, low bypasses
// R14 - Flag bit i describes data byte i
// R15 - Upper eight K and disparity bits unused
// R16 - Sequence match optionally includes disparity status
// R17 - Width 16/32/64 bypassed, 20/40/80 decoded (code: width sets the byte count only, decode enable picks the mode)
// R18 - Fabric drives decode enable to choose mode
// R19 - Data and flags leave together each cycle
`timescale 1ns/1ps
`include "rx8_regs.svh"

module rx8_decoder #(
	parameter int NB = 8 // Byte slices in the parallel word
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire logic [NB*10-1:0] rx_symbols,
	input wire logic rx_decode_enable,
	output logic [NB*8-1:0] rx_parallel_word,
	output logic [2*NB-1:0] rx_k_flag,
	output logic [2*NB-1:0] rx_disp_err_flag,
	output logic [NB-1:0] rx_comma_flag,
	output logic [NB-1:0] rx_not_in_table_flag,
	output logic [NB-1:0] rx_seq_disp_err
);

	// ----------------------------------------
	// Registers and internal state
	// ----------------------------------------
	logic [5:0] ctrl; // Comma options, sequence match, width
	logic [`RX8_EV_W-1:0] status; // Sticky events
	logic [`RX8_EV_W-1:0] mask; // Interrupt enables
	logic rd_state; // Disparity carried into next word
	logic next_rd;
	// Per-slice results of the current word, ahead of the output flops
	logic [NB*8-1:0] next_word;
	logic [NB-1:0] next_k;
	logic [NB-1:0] next_de;
	logic [NB-1:0] next_comma;
	logic [NB-1:0] next_nit;
	logic [`RX8_EV_W-1:0] ev_set; // Events found this word
	logic [`RX8_EV_W-1:0] ev_clr; // Bits cleared by a status read
	logic acc_take; // Access phase completes now
	logic acc_first; // First access cycle, answer prepared
	logic [31:0] rd_mux;
	logic addr_bad;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------

	// Bytes that carry data for a width code
	// Codes 2 and 3 both select the full word
	function automatic int bytes_for(input logic [1:0] w);
		if (w == `RX8_WID_2B) begin
			return 2;
		end else if (w == `RX8_WID_4B) begin
			return 4;
		end else begin
			return NB;
		end
	endfunction

	// Lane delivers the first-received bit last; decoder wants a first
	function automatic rx8_pkg::rx8_sym_t rev10(input rx8_pkg::rx8_sym_t s);
		rx8_pkg::rx8_sym_t r;
		for (int b = 0; b < 10; b++) begin
			r[b] = s[9-b];
		end
		return r;
	endfunction

	// Decode one symbol, abcdei in p[9:4], fghj in p[3:0]
	function automatic rx8_pkg::rx8_dec_s dec_sym(input rx8_pkg::rx8_sym_t p,
		input logic rd);
		rx8_pkg::rx8_dec_s o;
		logic [5:0] s6;
		logic [3:0] s4;
		logic [3:0] f4;
		logic [2:0] n6;
		logic [2:0] n4;
		logic [4:0] d5;
		logic [2:0] d3;
		logic k28, kx7, alt, prim7, bad6, bad4, de6, de4, rd6;
		s6 = p[9:4];
		s4 = p[3:0];
		n6 = 3'($countones(s6));
		n4 = 3'($countones(s4));
		// Six-bit sub-block, one line per value, both polarities where they differ
		case (s6)
			6'b100111, 6'b011000: d5 = 5'h00;
			6'b011101, 6'b100010: d5 = 5'h01;
			6'b101101, 6'b010010: d5 = 5'h02;
			6'b110001: d5 = 5'h03;
			6'b110101, 6'b001010: d5 = 5'h04;
			6'b101001: d5 = 5'h05;
			6'b011001: d5 = 5'h06;
			6'b111000, 6'b000111: d5 = 5'h07;
			6'b111001, 6'b000110: d5 = 5'h08;
			6'b100101: d5 = 5'h09;
			6'b010101: d5 = 5'h0a;
			6'b110100: d5 = 5'h0b;
			6'b001101: d5 = 5'h0c;
			6'b101100: d5 = 5'h0d;
			6'b011100: d5 = 5'h0e;
			6'b010111, 6'b101000: d5 = 5'h0f;
			6'b011011, 6'b100100: d5 = 5'h10;
			6'b100011: d5 = 5'h11;
			6'b010011: d5 = 5'h12;
			6'b110010: d5 = 5'h13;
			6'b001011: d5 = 5'h14;
			6'b101010: d5 = 5'h15;
			6'b011010: d5 = 5'h16;
			6'b111010, 6'b000101: d5 = 5'h17;
			6'b110011, 6'b001100: d5 = 5'h18;
			6'b100110: d5 = 5'h19;
			6'b010110: d5 = 5'h1a;
			6'b110110, 6'b001001: d5 = 5'h1b;
			6'b001110, 6'b001111, 6'b110000: d5 = 5'h1c;
			6'b101110, 6'b010001: d5 = 5'h1d;
			6'b011110, 6'b100001: d5 = 5'h1e;
			6'b101011, 6'b010100: d5 = 5'h1f;
			default: d5 = 5'h00;
		endcase
		k28 = (s6 == 6'b001111) || (s6 == 6'b110000);
		// K28 in form 110000 inverts its four-bit block
		f4 = (s6 == 6'b110000) ? ~s4 : s4;
		case (f4)
			4'b1011, 4'b0100: d3 = 3'h0;
			4'b1001: d3 = 3'h1;
			4'b0101: d3 = 3'h2;
			4'b1100, 4'b0011: d3 = 3'h3;
			4'b1101, 4'b0010: d3 = 3'h4;
			4'b1010: d3 = 3'h5;
			4'b0110: d3 = 3'h6;
			default: d3 = 3'h7;
		endcase
		alt = (s4 == 4'b0111) || (s4 == 4'b1000);
		prim7 = (s4 == 4'b1110) || (s4 == 4'b0001);
		kx7 = alt && (s6[1] != s6[0]) &&
			(d5 == 5'h17 || d5 == 5'h1b || d5 == 5'h1d || d5 == 5'h1e);
		// Codes outside the table, and runs of five across the boundary
		bad6 = (n6 < 3'd2) || (n6 > 3'd4) || (s6 == 6'b111100) ||
			(s6 == 6'b000011);
		bad4 = (s4 == 4'b0000) || (s4 == 4'b1111) ||
			(alt && !(kx7 || k28 || (s6[1] == s6[0] && s4[3] != s6[1]))) ||
			(prim7 && s6[1] == s6[0] && s4[3] == s6[1]);
		// Each unbalanced block must oppose the disparity it meets
		de6 = (n6 == 3'd4 && rd) || (n6 == 3'd2 && !rd) ||
			(s6 == 6'b111000 && rd) || (s6 == 6'b000111 && !rd);
		rd6 = (n6 == 3'd3) ? rd : (n6 == 3'd4);
		de4 = (n4 == 3'd3 && rd6) || (n4 == 3'd1 && !rd6) ||
			(s4 == 4'b1100 && rd6) || (s4 == 4'b0011 && !rd6);
		o.rd_out = (n4 == 3'd2) ? rd6 : (n4 == 3'd3);
		o.data = {d3, d5};
		o.k = k28 || kx7;
		o.disp_err = de6 || de4;
		o.not_in_table = bad6 || bad4;
		// Comma patterns look only at the first seven code bits
		o.plus_comma = (p[9:3] == 7'b0011111);
		o.minus_comma = (p[9:3] == 7'b1100000);
		o.std_comma = k28 && (d3 == 3'h1 || d3 == 3'h5 || d3 == 3'h7);
		return o;
	endfunction

	// ----------------------------------------
	// Slice datapath
	// ----------------------------------------

	// Walk the slices in byte order, passing disparity along
	always_comb begin
		logic rd;
		int nb;
		rx8_pkg::rx8_sym_t sym;
		rx8_pkg::rx8_dec_s o;
		rd = rd_state;
		nb = bytes_for(ctrl[`RX8_CTRL_WHI:`RX8_CTRL_WLO]); // [R04] [R17]
		sym = '0;
		o = '0;
		next_word = '0;
		next_k = '0;
		next_de = '0;
		next_comma = '0;
		next_nit = '0;
		// Bytes past the active width stay zero and leave the disparity
		// chain alone, so a narrow word seeds the next from its last byte
		for (int i = 0; i < NB; i++) begin // [R01]
			if (i < nb) begin
				// Slice i owns symbol i and flag bit i
				sym = rx_symbols[i*10 +: 10]; // [R14]
				if (!rx_decode_enable) begin
					// Raw path, same latency as decode, disparity untouched
					next_word[i*8 +: 8] = sym[7:0]; // [R05] [R13] [R18]
					next_k[i] = sym[8]; // [R05]
					next_de[i] = sym[9]; // [R05]
				end else begin
					o = dec_sym(rev10(sym), rd); // [R03]
					rd = o.rd_out; // [R02]
					if (o.not_in_table) begin
						// Unknown symbol goes out undecoded
						next_nit[i] = 1'b1; // [R07]
						next_word[i*8 +: 8] = sym[7:0]; // [R08]
						next_k[i] = sym[8]; // [R08]
						next_de[i] = sym[9]; // [R08]
					end else begin
						next_word[i*8 +: 8] = o.data;
						next_k[i] = o.k; // [R09]
						next_de[i] = o.disp_err; // [R06]
						if (ctrl[`RX8_CTRL_STD]) begin
							next_comma[i] = o.std_comma; // [R12]
						end else begin
							next_comma[i] = (o.plus_comma && ctrl[`RX8_CTRL_PCOM]) || // [R10]
								(o.minus_comma && ctrl[`RX8_CTRL_MCOM]); // [R11]
						end
					end
				end
			end
		end
		next_rd = rd; // [R02]
	end

	// Events of this word for the sticky status
	// Undecoded symbols carry a literal bit 9 on the disparity flag, which
	// is data and not an error, so they are left out of the event
	always_comb begin
		ev_set = '0;
		ev_set[`RX8_EV_DISP] = |(next_de & ~next_nit) && rx_decode_enable; // [R06]
		ev_set[`RX8_EV_NIT] = |next_nit;
		ev_set[`RX8_EV_COMMA] = |next_comma;
	end

	// Disparity from the last active slice seeds the next word
	// Bypass leaves it untouched, so decoding resumes where it paused
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_state <= 1'b0;
		end else if (clk_en) begin
			rd_state <= next_rd; // [R02]
		end
	end

	// All outputs of a word leave on the same edge
	// clk_en low holds the last word, so the fabric never sees a partial one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_parallel_word <= '0;
			rx_k_flag <= '0;
			rx_disp_err_flag <= '0;
			rx_comma_flag <= '0;
			rx_not_in_table_flag <= '0;
			rx_seq_disp_err <= '0;
		end else if (clk_en) begin
			rx_parallel_word <= next_word; // [R19]
			rx_k_flag <= {{NB{1'b0}}, next_k}; // [R15]
			rx_disp_err_flag <= {{NB{1'b0}}, next_de}; // [R15]
			rx_comma_flag <= next_comma;
			rx_not_in_table_flag <= next_nit;
			// Matcher sees disparity status only when asked to
			rx_seq_disp_err <= next_de & {NB{ctrl[`RX8_CTRL_SEQ]}}; // [R16]
		end
	end

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	// Access phases as seen from the slave side
	assign acc_take = psel && penable && pready;
	assign acc_first = psel && penable && !pready;

	// Address decode, unmapped offsets flagged
	// Exact word match; any other offset answers with an error
	always_comb begin
		rd_mux = '0;
		addr_bad = 1'b0;
		if (paddr == `RX8_CTRL_OFS) begin
			rd_mux[5:0] = ctrl;
		end else if (paddr == `RX8_STAT_OFS) begin
			rd_mux[`RX8_EV_W-1:0] = status;
		end else if (paddr == `RX8_MASK_OFS) begin
			rd_mux[`RX8_EV_W-1:0] = mask;
		end else begin
			addr_bad = 1'b1;
		end
	end

	// One wait state: answer on the second access cycle
	// Trade-off: the wait state keeps the read mux off the ready path
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else if (clk_en) begin
			pready <= acc_first;
			pslverr <= acc_first && addr_bad;
			// Data captured one edge before the status clear
			if (acc_first && !pwrite) begin
				prdata <= rd_mux;
			end else begin
				prdata <= '0;
			end
		end
	end

	// Writable control and mask, taken at the completing edge
	// Writes to status or unmapped offsets are dropped without effect
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= `RX8_CTRL_RST;
			mask <= `RX8_MASK_RST;
		end else if (clk_en && acc_take && pwrite) begin
			if (paddr == `RX8_CTRL_OFS) begin
				ctrl <= pwdata[5:0];
			end else if (paddr == `RX8_MASK_OFS) begin
				mask <= pwdata[`RX8_EV_W-1:0];
			end
		end
	end

	// ----------------------------------------
	// Interrupts
	// ----------------------------------------
	// A status read clears only the bits it reported; read data is taken
	// one edge before the completing edge, so an event landing in between
	// stays pending instead of being lost with the clear
	assign ev_clr = (acc_take && !pwrite && paddr == `RX8_STAT_OFS) ?
		prdata[`RX8_EV_W-1:0] : '0;

	// Sticky status; a new event beats the read clear
	// Only clk_en edges count, so a frozen block also holds its events
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status <= '0;
		end else if (clk_en) begin
			status <= (status & ~ev_clr) | ev_set;
		end
	end

	// Level interrupt while any unmasked bit stands
	// Registered, so the pin lags the status bit by one edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else if (clk_en) begin
			irq <= |(status & mask);
		end
	end

endmodule

// File: rx8_decoder_sva.sv
// Port assertions for the receive decoder
`timescale 1ns/1ps
module rx8_decoder_chk #(
	parameter int NB = 8 // Byte slices
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [NB*10-1:0] rx_symbols,
	input wire logic rx_decode_enable,
	input wire logic [NB*8-1:0] rx_parallel_word,
	input wire logic [2*NB-1:0] rx_k_flag,
	input wire logic [2*NB-1:0] rx_disp_err_flag,
	input wire logic [NB-1:0] rx_comma_flag,
	input wire logic [NB-1:0] rx_not_in_table_flag,
	input wire logic [NB-1:0] rx_seq_disp_err
);
	// ----------
	// One domain
	// ----------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	chk_upper_zero: assert property (
		{rx_k_flag[2*NB-1:NB], rx_disp_err_flag[2*NB-1:NB]} == '0)
		else $error("upper flags set");
	// Past reset check keeps the first edge quiet
	chk_bypass_raw: assert property (
		$past(presetn) && $past(clk_en) && !$past(rx_decode_enable) |->
		{rx_disp_err_flag[0], rx_k_flag[0], rx_parallel_word[7:0]} == $past(rx_symbols[9:0]))
		else $error("bypass byte not raw");
	chk_nit_raw: assert property (rx_not_in_table_flag[0] && $past(clk_en) |->
		{rx_disp_err_flag[0], rx_k_flag[0], rx_parallel_word[7:0]} == $past(rx_symbols[9:0])
		&& !rx_comma_flag[0])
		else $error("bad symbol not raw");
	chk_k28_decode: assert property (
		$past(presetn) && $past(clk_en) && $past(rx_decode_enable)
		&& $past(rx_symbols[9:0]) == 10'h17c |-> rx_k_flag[0] && rx_parallel_word[7:0] == 8'hbc)
		else $error("comma not decoded");
	chk_freeze_hold: assert property (!clk_en |=> $stable(rx_parallel_word) && $stable(rx_k_flag))
		else $error("output moved while frozen");
	chk_seq_subset: assert property ((rx_seq_disp_err & ~rx_disp_err_flag[NB-1:0]) == '0)
		else $error("seq flag without error");
	chk_ready_pulse: assert property (pready |-> psel && penable ##1 !pready)
		else $error("ready not a pulse");
	chk_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
endmodule

bind rx8_decoder rx8_decoder_chk #(.NB(NB)) u_chk (.pclk, .presetn, .clk_en, .psel, .penable,
	.pready, .pslverr, .rx_symbols, .rx_decode_enable, .rx_parallel_word, .rx_k_flag,
	.rx_disp_err_flag, .rx_comma_flag, .rx_not_in_table_flag, .rx_seq_disp_err);

// File: rx8_fabric_model.sv
// Fabric-side model choosing decode or bypass
`timescale 1ns/1ps
module rx8_fabric_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic want_decode,
	output logic rx_decode_enable
);
	// Mode moves on an edge only, never mid-cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_decode_enable <= 1'b1; // Decode by default
		end else begin
			rx_decode_enable <= want_decode;
		end
	end
endmodule

// File: rx8_pkg.sv
// Types shared by the receive decoder
package rx8_pkg;

	// Result of decoding one symbol in one slice
	typedef struct packed {
		logic [7:0] data;
		logic k;
		logic disp_err;
		logic not_in_table;
		logic plus_comma;
		logic minus_comma;
		logic std_comma;
		logic rd_out;
	} rx8_dec_s;

	// One raw ten-bit line symbol
	typedef logic [9:0] rx8_sym_t;

endpackage

// File: rx8_regs.svh
// Register offsets, field positions, reset values and codes of the receive decoder
`ifndef RX8_REGS_SVH
`define RX8_REGS_SVH

// ----------------------------------------
// Register byte offsets on the APB slave
// ----------------------------------------
`define RX8_CTRL_OFS 12'h000
`define RX8_STAT_OFS 12'h004
`define RX8_MASK_OFS 12'h008

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define RX8_CTRL_PCOM 0
`define RX8_CTRL_MCOM 1
`define RX8_CTRL_STD 2
`define RX8_CTRL_SEQ 3
`define RX8_CTRL_WLO 4
`define RX8_CTRL_WHI 5
`define RX8_CTRL_RST 6'h33

// ----------------------------------------
// Status and mask fields (same layout)
// ----------------------------------------
`define RX8_EV_DISP 0
`define RX8_EV_NIT 1
`define RX8_EV_COMMA 2
`define RX8_EV_W 3
`define RX8_MASK_RST 3'h0

// ----------------------------------------
// Width codes: 2, 4 or 8 bytes per word
// ----------------------------------------
`define RX8_WID_2B 2'h0
`define RX8_WID_4B 2'h1
`define RX8_WID_8B 2'h2

`endif

// File: testbench.sv
// Self-checking bench for the receive decoder
`timescale 1ns/1ps
module testbench;
	// ----------
	// Signals
	// ----------
	logic pclk, presetn, clk_en, psel, penable, pwrite, want_decode, er, pready, pslverr, irq;
	logic rx_decode_enable;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [79:0] rx_symbols;
	logic [63:0] rx_parallel_word;
	logic [15:0] rx_k_flag, rx_disp_err_flag;
	logic [7:0] rx_comma_flag, rx_not_in_table_flag, rx_seq_disp_err;
	int num_errors, num_checks;
	// Alternating comma forms, neutral per word
	localparam logic [79:0] WA = {4{10'h283, 10'h17c}};
	// Swapped forms: wrong polarity at byte 0
	localparam logic [79:0] WB = {4{10'h17c, 10'h283}};
	// Neutral data in the top two bytes
	localparam logic [79:0] WC = {10'h0b9, 10'h0b9, WA[59:0]};
	// Unknown code in byte 0
	localparam logic [79:0] WN = {WA[79:10], 10'h3ff};
	// Raw bypass symbols
	localparam logic [79:0] WR = {10'h3a5, 10'h1c3, 10'h255, 10'h0f0,
		10'h300, 10'h0ff, 10'h2aa, 10'h155};
	rx8_decoder #(.NB(8)) dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .irq, .rx_symbols, .rx_decode_enable,
		.rx_parallel_word, .rx_k_flag, .rx_disp_err_flag, .rx_comma_flag,
		.rx_not_in_table_flag, .rx_seq_disp_err);
	rx8_fabric_model fab (.pclk, .presetn, .want_decode, .rx_decode_enable);
	// 100 MHz clock
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// ----------
	// Shared tasks
	// ----------
	task automatic close_out();
		$display("errors %0d checks %0d", num_errors, num_checks);
		if (num_errors == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string nm);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// APB transfer; waits bounded for ready
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			num_errors++;
			close_out();
		end
	endtask
	task automatic rst();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
	endtask
	// One word for one cycle, then the filler
	task automatic word(input logic [79:0] s, input logic [79:0] nxt);
		@(posedge pclk);
		rx_symbols <= s;
		@(posedge pclk);
		rx_symbols <= nxt;
		#1;
	endtask
	task automatic dec(input logic [79:0] s, input logic [63:0] d, input logic [7:0] k);
		word(s, WA);
		chk(rx_parallel_word, d, "data");
		chk(64'(rx_k_flag), 64'(k), "k");
		chk(64'(rx_comma_flag), 64'(k), "comma");
		chk(64'(rx_disp_err_flag), 64'h0, "disp");
		chk(64'(rx_not_in_table_flag), 64'h0, "nit");
	endtask
	// ----------
	// Scenarios
	// ----------
	task automatic regs_and_decode();
		apb(1'b0, 12'h000, 32'h0);
		chk(64'(rd), 64'h33, "ctrl");
		apb(1'b0, 12'h00c, 32'h0);
		chk(64'(er), 64'h1, "unmapped");
		dec(WA, 64'hbcbcbcbcbcbcbcbc, 8'hff);
		dec(WC, 64'h0000bcbcbcbcbcbc, 8'h3f);
	endtask
	task automatic comma_modes();
		logic [7:0] ctl [4] = '{8'h32, 8'h31, 8'h30, 8'h34};
		logic [7:0] cf [4] = '{8'haa, 8'h55, 8'h00, 8'hff};
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, 12'h000, 32'(ctl[i]));
			apb(1'b0, 12'h000, 32'h0);
			chk(64'(rd), 64'(ctl[i]), "ctrl back");
			word(WA, WA);
			chk(64'(rx_comma_flag), 64'(cf[i]), "comma");
		end
		apb(1'b1, 12'h000, 32'h03);
		dec(WA, 64'hbcbc, 8'h03);
		apb(1'b1, 12'h000, 32'h13);
		dec(WA, 64'hbcbcbcbc, 8'h0f);
		apb(1'b1, 12'h000, 32'h33);
	endtask
	task automatic bypass_and_freeze();
		@(posedge pclk);
		want_decode <= 1'b0; // Bypass
		word(WR, WA);
		chk(rx_parallel_word, 64'ha5c355f000ffaa55, "raw data");
		chk(64'({rx_disp_err_flag, rx_k_flag}), 64'h00aa00c9, "raw flags");
		// Still in bypass at this edge: raw comma word is taken, then held
		@(posedge pclk);
		want_decode <= 1'b1;
		clk_en <= 1'b0; // Freeze: outputs hold the raw comma word
		rx_symbols <= WC;
		repeat (3) @(posedge pclk);
		clk_en <= 1'b1;
		rx_symbols <= WA;
		#1;
		chk(64'(rx_k_flag), 64'h0055, "frozen k");
		chk(rx_parallel_word, 64'h837c837c837c837c, "frozen data");
	endtask
	task automatic bad_symbol();
		chk(64'(irq), 64'h0, "irq masked");
		apb(1'b1, 12'h008, 32'h2);
		word(WN, WA);
		chk(64'(rx_not_in_table_flag), 64'h01, "nit");
		chk(64'({rx_disp_err_flag[0], rx_k_flag[0], rx_parallel_word[7:0]}), 64'h3ff, "nit raw");
		repeat (2) @(posedge pclk);
		#1;
		chk(64'(irq), 64'h1, "irq set");
		apb(1'b0, 12'h004, 32'h0);
		chk(64'(rd[1]), 64'h1, "status");
		repeat (2) @(posedge pclk);
		#1;
		chk(64'(irq), 64'h0, "irq clear");
	endtask
	task automatic disparity_chain();
		apb(1'b1, 12'h000, 32'h3b);
		word(WA, WA);
		chk(64'(rx_disp_err_flag), 64'h0, "disp clean");
		word(WB, WA);
		chk(64'(rx_disp_err_flag[0]), 64'h1, "disp err");
		chk(64'(rx_seq_disp_err[0]), 64'h1, "seq");
	endtask
	// ----------
	// Main sequence
	// ----------
	initial begin
		presetn = 1'b0;
		clk_en = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		want_decode = 1'b1;
		rx_symbols = WA;
		num_errors = 0;
		num_checks = 0;
		rst();
		regs_and_decode();
		comma_modes();
		bypass_and_freeze();
		bad_symbol();
		rst(); // Known disparity again after the bad symbol
		disparity_chain();
		close_out();
	end
endmodule
